// ==== hw/iev_defs.svh ====
/*
 * constants of the interrupt and exception vectoring block: codes, handler
 * offsets, source counts and filter length.
 * assumes it is included by bare name from the package and design modules.
 */
`ifndef IEV_DEFS_SVH
`define IEV_DEFS_SVH

// source counts
`define IEV_NUM_SRC 40
`define IEV_NUM_PIN 8
`define IEV_NUM_LVL 8
`define IEV_SRC_W 6
`define IEV_LVL_W 3

// pin positions: index 0 is the non-maskable pin, 1..7 are maskable pins
`define IEV_PIN_NMI 0
`define IEV_PIN_FIRST_SRC 1

// exception codes
`define IEV_CODE_RESET 16'h0000
`define IEV_CODE_NMI 16'h0010
`define IEV_CODE_WDT 16'h0020
`define IEV_CODE_TRAP_A 16'h0040
`define IEV_CODE_TRAP_B 16'h0050
`define IEV_CODE_ILG 16'h0060
`define IEV_CODE_MASK_BASE 16'h0080
`define IEV_CODE_STEP 16'h0010
`define IEV_HANDLER_LOW_CLR 16'hfff0

// trap number layout
`define IEV_TRAP_GRP_BIT 4

// noise filter: samples that must agree before a level is believed
`define IEV_NF_SAMPLES 3

// edge select encodings
`define IEV_EDGE_NONE 2'h0
`define IEV_EDGE_RISE 2'h1
`define IEV_EDGE_FALL 2'h2
`define IEV_EDGE_BOTH 2'h3

`endif

// ==== hw/iev_pkg.sv ====
/*
 * types shared by the vectoring block and its pin filter.
 * assumes iev_defs.svh sits on the include path.
 */
`include "iev_defs.svh"

package iev_pkg;

    // what kind of event is offered to the core
    typedef enum logic [2:0] {
        IEV_K_RESET = 3'h0,
        IEV_K_NMI = 3'h1,
        IEV_K_WDT = 3'h2,
        IEV_K_TRAP = 3'h3,
        IEV_K_ILG = 3'h4,
        IEV_K_MASK = 3'h5
    } iev_kind_t;

    typedef enum logic [0:0] {
        IEV_S_IDLE = 1'h0,
        IEV_S_OFFER = 1'h1
    } iev_fsm_t;

    // vector handed to the core
    typedef struct packed {
        logic req;
        iev_kind_t kind;
        logic [15:0] code;
        logic [31:0] handler;
    } iev_vec_t;

    // pin filter state
    typedef struct packed {
        logic [`IEV_NF_SAMPLES-1:0] samp;
        logic stable;
        logic pulse;
    } iev_filt_t;

    // whole controller state
    typedef struct packed {
        iev_fsm_t fsm;
        logic [`IEV_NUM_SRC-1:0] pend;
        logic nmi_pend;
        logic wdt_pend;
        logic trap_pend;
        logic [4:0] trap_num;
        logic ilg_pend;
        logic [`IEV_NUM_LVL-1:0] isr;
        logic nmi_busy;
        logic [`IEV_SRC_W-1:0] src;
        logic [`IEV_LVL_W-1:0] lvl;
        iev_vec_t vec;
        logic [31:0] save_m;
        logic [31:0] save_n;
    } iev_state_t;

endpackage

// ==== hw/iev_pin_filter.sv ====
/*
 * noise elimination and valid-edge detection for one external request pin.
 * assumes the pin is already synchronous to core_clk.
 */
`timescale 1ns/1ns
`include "iev_defs.svh"

module iev_pin_filter (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pin and edge choice
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    // one-cycle valid edge
    output logic valid_edge
);

    iev_pkg::iev_filt_t st;
    iev_pkg::iev_filt_t next_st;
    logic all_hi;
    logic all_lo;

    // a level is believed only once every sample agrees
    always_comb begin
        next_st = st;
        next_st.samp = {st.samp[`IEV_NF_SAMPLES-2:0], pin};
        all_hi = &st.samp;
        all_lo = ~|st.samp;
        next_st.pulse = 1'b0;
        if (all_hi && !st.stable) begin
            next_st.stable = 1'b1;
            next_st.pulse = edge_sel[0];
        end else if (all_lo && st.stable) begin
            next_st.stable = 1'b0;
            next_st.pulse = edge_sel[1];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign valid_edge = st.pulse; // registered pulse

endmodule // iev_pin_filter

// ==== hw/iev_arbiter.sv ====
/*
 * interrupt and exception vectoring: collects reset, non-maskable, trap and
 * maskable requests, arbitrates by programmed level and default order, tracks
 * nesting and offers one vector at a time to the processor core.
 * assumes peripheral requests are one-cycle pulses synchronous to core_clk,
 * that the core pulses core_accept once per offered vector, and that the
 * core reports handler returns on its return strobes.
 */
`timescale 1ns/1ns
`include "iev_defs.svh"

module irq_arbiter_unit (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic watchdog_reset_cause,
    // external pins, index 0 non-maskable, 1..7 maskable
    input wire logic [`IEV_NUM_PIN-1:0] ext_pin,
    input wire logic [2*`IEV_NUM_PIN-1:0] ext_edge_sel,
    // on-chip request pulses, one per maskable source except 1..7, which take pins
    input wire logic [`IEV_NUM_SRC-1:0] periph_req,
    input wire logic watchdog_nonmaskable_request,
    // per-source level and mask
    input wire logic [`IEV_LVL_W*`IEV_NUM_SRC-1:0] src_level,
    input wire logic [`IEV_NUM_SRC-1:0] src_mask,
    // exceptions from the core
    input wire logic illegal_opcode_trap,
    input wire logic debug_break_instruction,
    input wire logic software_trap_req,
    input wire logic [4:0] software_trap_num,
    // acceptance and return from the core
    input wire logic core_accept,
    input wire logic [31:0] following_instruction_address,
    input wire logic core_return_maskable,
    input wire logic core_return_nonmaskable,
    // vector offered to the core
    output iev_pkg::iev_vec_t exc_vec,
    output logic [`IEV_LVL_W-1:0] exc_level,
    // saved return addresses
    output logic [31:0] maskable_return_pc_save,
    output logic [31:0] nonmaskable_return_pc_save,
    // nesting status
    output logic [`IEV_NUM_LVL-1:0] in_service
);

    iev_pkg::iev_state_t st;
    iev_pkg::iev_state_t next_st;
    logic [`IEV_NUM_PIN-1:0] pin_edge;
    logic [`IEV_NUM_SRC-1:0] src_set;
    logic [`IEV_NUM_SRC-1:0] src_clr;
    logic [`IEV_NUM_SRC-1:0] eligible;
    logic win_ok;
    logic [`IEV_SRC_W-1:0] win_src;
    logic [`IEV_LVL_W-1:0] win_lvl;
    logic cur_ok;
    logic [`IEV_LVL_W-1:0] cur_lvl;
    logic pass_nest;

    // handler address is the code with its low nibble cleared, zero-extended
    function automatic logic [31:0] handler_of(input logic [15:0] code);
        handler_of = {16'h0000, code & `IEV_HANDLER_LOW_CLR};
    endfunction

    // build a vector from kind and code
    function automatic iev_pkg::iev_vec_t make_vec(input iev_pkg::iev_kind_t k,
                                                   input logic [15:0] code);
        make_vec.req = 1'b1;
        make_vec.kind = k;
        make_vec.code = code;
        make_vec.handler = handler_of(code);
    endfunction

    // level of one source out of the packed level bus
    function automatic logic [`IEV_LVL_W-1:0] level_of(input int unsigned idx,
            input logic [`IEV_LVL_W*`IEV_NUM_SRC-1:0] bus);
        level_of = bus[idx*`IEV_LVL_W +: `IEV_LVL_W];
    endfunction

    genvar g;
    generate
        for (g = 0; g < `IEV_NUM_PIN; g = g + 1) begin : g_pin
            iev_pin_filter u_filt (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .pin(ext_pin[g]),
                .edge_sel(ext_edge_sel[2*g +: 2]),
                .valid_edge(pin_edge[g])
            );
        end
    endgenerate

    // pins 1..7 replace on-chip requests at sources 1..7
    always_comb begin
        src_set = periph_req;
        for (int i = `IEV_PIN_FIRST_SRC; i < `IEV_NUM_PIN; i++) begin
            src_set[i] = pin_edge[i];
        end
    end

    // masked or already-serviced sources drop out
    assign eligible = st.pend & ~src_mask;

    // ties go to the lower index by scanning downward with <=
    always_comb begin
        win_ok = 1'b0;
        win_src = '0;
        win_lvl = '0;
        for (int i = `IEV_NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i] && (!win_ok || level_of(i, src_level) <= win_lvl)) begin
                win_ok = 1'b1;
                win_src = i[`IEV_SRC_W-1:0];
                win_lvl = level_of(i, src_level);
            end
        end
    end

    // current running level is the best level still in service
    always_comb begin
        cur_ok = 1'b0;
        cur_lvl = '0;
        for (int l = `IEV_NUM_LVL - 1; l >= 0; l--) begin
            if (st.isr[l]) begin
                cur_ok = 1'b1;
                cur_lvl = l[`IEV_LVL_W-1:0];
            end
        end
    end

    // strictly better level preempts; equal or worse waits
    assign pass_nest = win_ok && (!cur_ok || win_lvl < cur_lvl);

    // next state: pending capture, arbitration, offer and acceptance
    always_comb begin
        next_st = st;
        src_clr = '0;

        if (pin_edge[`IEV_PIN_NMI]) begin
            next_st.nmi_pend = 1'b1;
        end
        if (watchdog_nonmaskable_request) begin
            next_st.wdt_pend = 1'b1;
        end
        // illegal opcode and debug break share one trap
        if (illegal_opcode_trap || debug_break_instruction) begin
            next_st.ilg_pend = 1'b1;
        end
        // software trap number captured with its request
        if (software_trap_req) begin
            next_st.trap_pend = 1'b1;
            next_st.trap_num = software_trap_num;
        end

        // nesting bookkeeping on handler return
        if (core_return_maskable && cur_ok) begin
            next_st.isr[cur_lvl] = 1'b0;
        end
        if (core_return_nonmaskable) begin
            next_st.nmi_busy = 1'b0;
        end

        unique case (st.fsm)
            iev_pkg::IEV_S_IDLE: begin
                // exceptions come before interrupts; nmi blocks maskable
                if (st.ilg_pend) begin
                    // a new trap in the clearing cycle stays pending
                    next_st.ilg_pend = illegal_opcode_trap || debug_break_instruction;
                    next_st.vec = make_vec(iev_pkg::IEV_K_ILG, `IEV_CODE_ILG);
                    next_st.fsm = iev_pkg::IEV_S_OFFER;
                end else if (st.trap_pend) begin
                    next_st.trap_pend = software_trap_req;
                    next_st.vec = make_vec(iev_pkg::IEV_K_TRAP,
                        (st.trap_num[`IEV_TRAP_GRP_BIT] ? `IEV_CODE_TRAP_B : `IEV_CODE_TRAP_A)
                        | {12'h000, st.trap_num[3:0]});
                    next_st.fsm = iev_pkg::IEV_S_OFFER;
                end else if (st.nmi_pend && !st.nmi_busy) begin
                    next_st.nmi_pend = pin_edge[`IEV_PIN_NMI];
                    next_st.vec = make_vec(iev_pkg::IEV_K_NMI, `IEV_CODE_NMI);
                    next_st.fsm = iev_pkg::IEV_S_OFFER;
                end else if (st.wdt_pend && !st.nmi_busy) begin
                    next_st.wdt_pend = watchdog_nonmaskable_request;
                    next_st.vec = make_vec(iev_pkg::IEV_K_WDT, `IEV_CODE_WDT);
                    next_st.fsm = iev_pkg::IEV_S_OFFER;
                end else if (pass_nest && !st.nmi_busy) begin
                    // code steps by one slot per source index
                    next_st.vec = make_vec(iev_pkg::IEV_K_MASK,
                        `IEV_CODE_MASK_BASE + 16'(`IEV_CODE_STEP * win_src));
                    next_st.src = win_src;
                    next_st.lvl = win_lvl;
                    next_st.fsm = iev_pkg::IEV_S_OFFER;
                end
            end
            iev_pkg::IEV_S_OFFER: begin
                if (core_accept) begin
                    next_st.fsm = iev_pkg::IEV_S_IDLE;
                    next_st.vec.req = 1'b0;
                    // save register chosen by event class
                    unique case (st.vec.kind)
                        iev_pkg::IEV_K_NMI, iev_pkg::IEV_K_WDT: begin
                            next_st.save_n = following_instruction_address;
                            next_st.nmi_busy = 1'b1;
                        end
                        iev_pkg::IEV_K_MASK: begin
                            next_st.save_m = following_instruction_address;
                            next_st.isr[st.lvl] = 1'b1;
                            src_clr[st.src] = 1'b1;
                        end
                        iev_pkg::IEV_K_TRAP, iev_pkg::IEV_K_ILG: begin
                            next_st.save_m = following_instruction_address;
                        end
                        // reset saves nothing; both save registers keep the zero that reset loads
                        iev_pkg::IEV_K_RESET: begin
                        end
                        default: begin
                        end
                    endcase
                end
            end
        endcase

        // a new request in the clearing cycle survives
        next_st.pend = (st.pend & ~src_clr) | src_set;

        // watchdog reset restarts everything but the pin filters, and offers the reset vector
        if (watchdog_reset_cause) begin
            next_st = '0;
            next_st.fsm = iev_pkg::IEV_S_OFFER;
            next_st.vec = make_vec(iev_pkg::IEV_K_RESET, `IEV_CODE_RESET);
        end
    end

    // pin reset offers the reset vector straight away
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.fsm <= iev_pkg::IEV_S_OFFER;
            st.vec.req <= 1'b1;
            st.vec.kind <= iev_pkg::IEV_K_RESET;
            st.vec.code <= `IEV_CODE_RESET;
            st.vec.handler <= {16'h0000, `IEV_CODE_RESET};
        end else begin
            st <= next_st;
        end
    end

    // all outputs come straight from state flip-flops
    assign exc_vec = st.vec;
    assign exc_level = st.lvl;
    assign maskable_return_pc_save = st.save_m;
    assign nonmaskable_return_pc_save = st.save_n;
    assign in_service = st.isr;

endmodule // irq_arbiter_unit

// ==== verification/iev_arbiter_assertions.sv ====
/* port checker for the vectoring block.
   assumes it is bound to irq_arbiter_unit, whose port names it shares. */
`timescale 1ns/1ns
`include "iev_defs.svh"

module iev_arbiter_checker (
    // clock and resets
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic watchdog_reset_cause,
    // inputs that qualify an offer
    input wire logic [`IEV_NUM_SRC-1:0] src_mask,
    input wire logic core_accept,
    input wire logic [31:0] following_instruction_address,
    // outputs watched
    input iev_pkg::iev_vec_t exc_vec,
    input wire logic [`IEV_LVL_W-1:0] exc_level,
    input wire logic [31:0] maskable_return_pc_save,
    input wire logic [31:0] nonmaskable_return_pc_save,
    input wire logic [`IEV_NUM_LVL-1:0] in_service
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // a watchdog reset may legally replace a standing offer
    logic offer;
    logic [15:0] midx;
    logic [7:0] upto;
    assign offer = exc_vec.req && !watchdog_reset_cause;
    assign midx = (exc_vec.code - 16'h0080) >> 4;
    assign upto = (8'h02 << exc_level) - 8'h01;

    AST_HOLD: assert property (offer && !core_accept |=> exc_vec.req && $stable(exc_vec))
        else $error("offer changed before it was taken");
    AST_DROP: assert property (offer && core_accept |=> !exc_vec.req)
        else $error("offer stayed after accept");
    AST_NMI: assert property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_NMI |->
        exc_vec.code == 16'h0010 && exc_vec.handler == 32'h00000010) else $error("bad nmi vector");
    AST_WDT: assert property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_WDT |->
        exc_vec.code == 16'h0020 && exc_vec.handler == 32'h00000020) else $error("bad wdt vector");
    AST_ILG: assert property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_ILG |->
        exc_vec.code == 16'h0060 && exc_vec.handler == 32'h00000060) else $error("bad trap vector");
    AST_TRAP: assert property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_TRAP |->
        exc_vec.code[15:5] == 11'h002 && exc_vec.handler == {16'h0000, exc_vec.code[15:4], 4'h0})
        else $error("bad software trap vector");
    AST_MCODE: assert property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_MASK |->
        exc_vec.code[3:0] == 4'h0 && exc_vec.code >= 16'h0080 && exc_vec.code <= 16'h02f0
        && exc_vec.handler == {16'h0000, exc_vec.code}) else $error("bad maskable vector");
    AST_MASKED: assert property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_MASK |->
        !src_mask[midx[5:0]]) else $error("masked source offered");
    AST_NEST: assert property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_MASK |->
        (in_service & upto) == 8'h00) else $error("offer not above levels in service");
    AST_SAVEM: assert property (offer && core_accept && (exc_vec.kind == iev_pkg::IEV_K_MASK ||
        exc_vec.kind == iev_pkg::IEV_K_TRAP) |=> maskable_return_pc_save ==
        $past(following_instruction_address)) else $error("maskable save wrong");
    AST_SAVEN: assert property (offer && core_accept && (exc_vec.kind == iev_pkg::IEV_K_NMI ||
        exc_vec.kind == iev_pkg::IEV_K_WDT) |=> nonmaskable_return_pc_save ==
        $past(following_instruction_address)) else $error("nonmaskable save wrong");
    AST_WDRES: assert property (watchdog_reset_cause |-> ##[1:2] exc_vec.req &&
        exc_vec.kind == iev_pkg::IEV_K_RESET && exc_vec.handler == 32'h0 && in_service == 8'h00)
        else $error("watchdog reset vector missing");

    // main scenarios reached
    cover property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_NMI);
    cover property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_MASK && in_service != 8'h00);
    cover property (exc_vec.req && exc_vec.kind == iev_pkg::IEV_K_TRAP);
    cover property (watchdog_reset_cause);
endmodule // iev_arbiter_checker

// ==== verification/iev_core_model.sv ====
/* processor core model: takes each offered vector after a chosen delay.
   assumes the controller holds its offer until accepted. */
`timescale 1ns/1ns

module iev_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // offer and accept delay
    input iev_pkg::iev_vec_t exc_vec,
    input wire logic [3:0] lat,
    // towards the controller
    output logic core_accept,
    output logic [31:0] following_instruction_address
);
    logic [3:0] wait_cnt;
    logic [31:0] pc;
    // one accept pulse per offer, next address steps per accept
    always @(posedge core_clk) begin
        if (!rst_n) begin
            core_accept <= 1'b0;
            wait_cnt <= 4'h0;
            pc <= 32'h00001000;
        end else if (core_accept) begin
            core_accept <= 1'b0;
            wait_cnt <= 4'h0;
            pc <= pc + 32'h00000004;
        end else if (exc_vec.req && wait_cnt >= lat) begin
            core_accept <= 1'b1;
        end else if (exc_vec.req) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // address only meaningful with accept, scrambled otherwise
    assign following_instruction_address = core_accept ? pc : ~pc;
endmodule // iev_core_model

// ==== verification/irq_arbiter_unit_tb_top.sv ====
/* self-checking bench for the vectoring block, core model on the far side.
   assumes hw/ on the include path, design and model compiled first. */
`timescale 1ns/1ns
`include "iev_defs.svh"

module irq_arbiter_unit_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wd_rst = 1'b0;
    logic [7:0] ext_pin = 8'h00;
    logic [15:0] ext_edge_sel = 16'h5555;
    logic [39:0] periph_req = 40'h0;
    logic wd_nmi = 1'b0;
    logic [119:0] src_level = {120{1'b1}};
    logic [39:0] src_mask = 40'h0;
    logic ilg = 1'b0;
    logic dbg = 1'b0;
    logic trap = 1'b0;
    logic [4:0] trap_num = 5'h00;
    logic ret_m = 1'b0;
    logic ret_n = 1'b0;
    logic [3:0] lat = 4'h2;
    logic core_accept;
    logic [31:0] pc_out;
    logic [31:0] last_pc;
    iev_pkg::iev_vec_t exc_vec;
    logic [2:0] exc_level;
    logic [31:0] save_m;
    logic [31:0] save_n;
    logic [7:0] in_service;
    int failures = 0;
    int checks_done = 0;

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    irq_arbiter_unit irq_arbiter_unit_inst (.core_clk(core_clk), .rst_n(rst_n),
        .watchdog_reset_cause(wd_rst), .ext_pin(ext_pin), .ext_edge_sel(ext_edge_sel),
        .periph_req(periph_req), .watchdog_nonmaskable_request(wd_nmi), .src_level(src_level),
        .src_mask(src_mask), .illegal_opcode_trap(ilg), .debug_break_instruction(dbg),
        .software_trap_req(trap), .software_trap_num(trap_num), .core_accept(core_accept),
        .following_instruction_address(pc_out), .core_return_maskable(ret_m),
        .core_return_nonmaskable(ret_n), .exc_vec(exc_vec), .exc_level(exc_level),
        .maskable_return_pc_save(save_m), .nonmaskable_return_pc_save(save_n),
        .in_service(in_service));
    iev_core_model iev_core_model_inst (.core_clk(core_clk), .rst_n(rst_n), .exc_vec(exc_vec),
        .lat(lat), .core_accept(core_accept), .following_instruction_address(pc_out));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // wait for an offer, judge it, let the core take it
    task automatic offer(input logic [15:0] c, input logic [31:0] h);
        int k;
        k = 0;
        while (exc_vec.req !== 1'b1 && k < 300) begin
            tick(1);
            k++;
        end
        chk(exc_vec.req, 32'h1);
        chk(exc_vec.code, c);
        chk(exc_vec.handler, h);
        k = 0;
        while (core_accept !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        chk(core_accept, 32'h1);
        last_pc = pc_out;
        tick(2);
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            tick(1);
            chk(exc_vec.req, 32'h0);
        end
    endtask
    task automatic preq(input int i);
        periph_req[i] = 1'b1;
        tick(1);
        periph_req[i] = 1'b0;
    endtask
    task automatic ret(input bit nm);
        ret_n = nm;
        ret_m = !nm;
        tick(1);
        ret_m = 1'b0;
        ret_n = 1'b0;
        tick(1);
    endtask

    task automatic t_reset;
        chk(exc_vec.kind, 32'h0);
        offer(16'h0000, 32'h0);
        chk(in_service, 32'h0);
    endtask
    task automatic t_walk;
        src_level[29:27] = 3'h2;
        preq(9);
        offer(16'h0110, 32'h110);
        chk(exc_level, 32'h2);
        chk(save_m, last_pc);
        chk(in_service, 32'h4);
        ret(0);
        chk(in_service, 32'h0);
        src_level[29:27] = 3'h7;
    endtask
    // same-cycle requests, equal then different levels, last source
    task automatic t_tie;
        lat = 4'h0;
        periph_req = 40'h0000001200;
        tick(1);
        periph_req = 40'h0;
        offer(16'h0110, 32'h110);
        ret(0);
        offer(16'h0140, 32'h140);
        ret(0);
        src_level[38:36] = 3'h2;
        periph_req = 40'h0000001200;
        tick(1);
        periph_req = 40'h0;
        offer(16'h0140, 32'h140);
        ret(0);
        offer(16'h0110, 32'h110);
        ret(0);
        preq(39);
        offer(16'h02f0, 32'h2f0);
        ret(0);
        src_level = {120{1'b1}};
        lat = 4'h2;
    endtask
    task automatic t_nest;
        src_level[29:27] = 3'h3;
        src_level[38:36] = 3'h3;
        src_level[62:60] = 3'h1;
        preq(9);
        offer(16'h0110, 32'h110);
        preq(12);
        idle(10);
        preq(20);
        offer(16'h01c0, 32'h1c0);
        chk(exc_level, 32'h1);
        chk(in_service, 32'h0a);
        ret(0);
        idle(6);
        ret(0);
        offer(16'h0140, 32'h140);
        ret(0);
        src_level = {120{1'b1}};
    endtask
    task automatic t_mask;
        src_mask[10] = 1'b1;
        preq(10);
        idle(10);
        src_mask[10] = 1'b0;
        offer(16'h0120, 32'h120);
        ret(0);
    endtask
    task automatic t_pins;
        logic [15:0] c;
        for (int p = 1; p < 7; p++) begin
            c = 16'h0080 + 16'h0010 * p[15:0];
            ext_pin[p] = 1'b1;
            offer(c, {16'h0000, c});
            ret(0);
            ext_pin[p] = 1'b0;
            tick(6);
        end
        ext_edge_sel[15:14] = 2'h2;
        ext_pin[7] = 1'b1;
        idle(10);
        ext_pin[7] = 1'b0;
        offer(16'h00f0, 32'hf0);
        ret(0);
        // both edges count, then neither
        ext_edge_sel[15:14] = 2'h3;
        ext_pin[7] = 1'b1;
        offer(16'h00f0, 32'hf0);
        ret(0);
        ext_pin[7] = 1'b0;
        offer(16'h00f0, 32'hf0);
        ret(0);
        ext_edge_sel[15:14] = 2'h0;
        ext_pin[7] = 1'b1;
        idle(10);
        ext_pin[7] = 1'b0;
        idle(10);
    endtask
    task automatic t_nmi;
        ext_pin[0] = 1'b1;
        offer(16'h0010, 32'h10);
        chk(save_n, last_pc);
        wd_nmi = 1'b1;
        tick(1);
        wd_nmi = 1'b0;
        idle(8);
        ret(1);
        offer(16'h0020, 32'h20);
        chk(save_n, last_pc);
        ret(1);
        ext_pin[0] = 1'b0;
        tick(6);
    endtask
    task automatic t_traps;
        for (int n = 0; n < 32; n++) begin
            trap_num = n[4:0];
            trap = 1'b1;
            tick(1);
            trap = 1'b0;
            offer({11'h002, n[4:0]}, n[4] ? 32'h50 : 32'h40);
        end
        chk(save_m, last_pc);
        ilg = 1'b1;
        tick(1);
        ilg = 1'b0;
        offer(16'h0060, 32'h60);
        dbg = 1'b1;
        tick(1);
        dbg = 1'b0;
        offer(16'h0060, 32'h60);
    endtask
    // pending work must not survive a watchdog reset
    task automatic t_wdres;
        src_mask[9] = 1'b1;
        preq(9);
        wd_rst = 1'b1;
        tick(1);
        wd_rst = 1'b0;
        offer(16'h0000, 32'h0);
        chk(save_m, 32'h0);
        src_mask[9] = 1'b0;
        idle(8);
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence after 16 reset cycles
    initial begin
        tick(16);
        rst_n = 1'b1;
        t_reset;
        t_walk;
        t_tie;
        t_nest;
        t_mask;
        t_pins;
        t_nmi;
        t_traps;
        t_wdres;
        final_report;
    end
    // hang guard, far beyond the several hundred cycles expected
    initial begin
        #400000;
        failures++;
        final_report;
    end
endmodule // irq_arbiter_unit_tb_top

bind irq_arbiter_unit iev_arbiter_checker iev_arbiter_checker_inst (.core_clk(core_clk),
    .rst_n(rst_n), .watchdog_reset_cause(watchdog_reset_cause), .src_mask(src_mask),
    .core_accept(core_accept), .following_instruction_address(following_instruction_address),
    .exc_vec(exc_vec), .exc_level(exc_level), .maskable_return_pc_save(maskable_return_pc_save),
    .nonmaskable_return_pc_save(nonmaskable_return_pc_save), .in_service(in_service));
